// ---- rtl/rmt_regs.svh ----
// register offsets, field positions and reset values of the mode configuration bank
`ifndef RMT_REGS_SVH
`define RMT_REGS_SVH
`define RMT_ADDR_GENERAL 6'h11
`define RMT_ADDR_TRANSMIT 6'h12
`define RMT_ADDR_RECEIVE 6'h13
`define RMT_GENERAL_RESET 8'h3f
`define RMT_TRANSMIT_RESET 8'h00
`define RMT_RECEIVE_RESET 8'h00
`define RMT_GENERAL_WMASK 8'ha3
`define RMT_GENERAL_WMASK_POL 8'h08
`define RMT_TRANSMIT_WMASK 8'hf8
`define RMT_RECEIVE_WMASK 8'h80
`define RMT_BIT_HIGH_ORDER 7
`define RMT_BIT_WAIT_FIELD 5
`define RMT_BIT_POLARITY 3
`define RMT_BIT_SEED_HI 1
`define RMT_BIT_SEED_LO 0
`define RMT_BIT_SEND_CRC 7
`define RMT_BIT_RATE_HI 6
`define RMT_BIT_RATE_LO 4
`define RMT_BIT_MOD_INV 3
`define RMT_BIT_RECV_CRC 7
`define RMT_SEED_0 16'h0000
`define RMT_SEED_1 16'h6363
`define RMT_SEED_2 16'ha671
`define RMT_SEED_3 16'hffff
`define RMT_RATE_MAX 3'h3
`endif

// ---- rtl/rmt_pkg.sv ----
// types shared by the mode configuration bank
package rmt_pkg;
    typedef struct packed {
        logic [7:0] general_mode_cfg;
        logic [7:0] transmit_mode_cfg;
        logic [7:0] receive_mode_cfg;
        logic [7:0] rd_data;
        logic env_meta;
        logic env_sync;
        logic activity;
    } rmt_state_t;
endpackage

// ---- rtl/rmt_mode_regs.sv ----
// general, transmit and receive mode configuration registers with their derived controls
`timescale 1ns/1ps
`default_nettype none
`include "rmt_regs.svh"

module rmt_mode_regs
    import rmt_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [5:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic RF_ACTIVE_IN,
    input wire logic FIELD_ON_IN,
    input wire logic SEND_REQ_IN,
    input wire logic ENVELOPE_INPUT_PIN_IN,
    input wire logic [15:0] CRC_RAW_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic CRC_HIGH_BIT_ORDER_OUT,
    output logic [15:0] CRC_SEED_OUT,
    output logic [7:0] CRC_RESULT_HIGH_BYTE_OUT,
    output logic [7:0] CRC_RESULT_LOW_BYTE_OUT,
    output logic SEND_START_OUT,
    output logic ENVELOPE_N_OUT,
    output logic ENVELOPE_ACTIVITY_IRQ_OUT,
    output logic SEND_CRC_APPEND_ON_OUT,
    output logic RECEIVE_CRC_CHECK_ON_OUT,
    output logic [2:0] SEND_BIT_RATE_OUT,
    output logic SEND_RATE_RESERVED_OUT,
    output logic MODULATION_INVERT_OUT
);

    localparam int BYTE_BITS = 8;

    rmt_state_t state;
    rmt_state_t next_state;

    logic addr_general;
    logic addr_transmit;
    logic addr_receive;
    logic wr_general;
    logic wr_transmit;
    logic wr_receive;
    logic rd_general;
    logic rd_transmit;
    logic rd_receive;

    logic crc_high_bit_order;
    logic wait_for_field_before_send;
    logic envelope_in_polarity;
    logic [1:0] crc_seed_select;
    logic send_crc_append_on;
    logic [2:0] send_bit_rate;
    logic modulation_invert;
    logic receive_crc_check_on;

    logic polarity_toggle;
    logic [7:0] general_write_mask;
    logic [7:0] general_written;
    logic [7:0] transmit_written;
    logic [7:0] receive_written;
    logic [7:0] read_value;

    logic high_order;
    logic [15:0] crc_reversed;
    logic [15:0] crc_shown;
    logic auto_crc_used;
    logic [1:0] auto_sel;
    logic [1:0] seed_sel;
    logic [15:0] seed_value;
    logic field_ready;
    logic envelope_level_n;
    logic rate_reserved;

    assign addr_general = REG_ADDR_IN == `RMT_ADDR_GENERAL;
    assign addr_transmit = REG_ADDR_IN == `RMT_ADDR_TRANSMIT;
    assign addr_receive = REG_ADDR_IN == `RMT_ADDR_RECEIVE;
    assign wr_general = REG_WR_IN & addr_general;
    assign wr_transmit = REG_WR_IN & addr_transmit;
    assign wr_receive = REG_WR_IN & addr_receive;
    assign rd_general = REG_RD_IN & addr_general;
    assign rd_transmit = REG_RD_IN & addr_transmit;
    assign rd_receive = REG_RD_IN & addr_receive;

    assign crc_high_bit_order = state.general_mode_cfg[`RMT_BIT_HIGH_ORDER];
    assign wait_for_field_before_send = state.general_mode_cfg[`RMT_BIT_WAIT_FIELD];
    assign envelope_in_polarity = state.general_mode_cfg[`RMT_BIT_POLARITY];
    assign crc_seed_select = state.general_mode_cfg[`RMT_BIT_SEED_HI:`RMT_BIT_SEED_LO];
    assign send_crc_append_on = state.transmit_mode_cfg[`RMT_BIT_SEND_CRC];
    assign send_bit_rate = state.transmit_mode_cfg[`RMT_BIT_RATE_HI:`RMT_BIT_RATE_LO];
    assign modulation_invert = state.transmit_mode_cfg[`RMT_BIT_MOD_INV];
    assign receive_crc_check_on = state.receive_mode_cfg[`RMT_BIT_RECV_CRC];

    // reserved positions never take write data, so they keep their reset value
    assign general_write_mask = `RMT_GENERAL_WMASK | `RMT_GENERAL_WMASK_POL;
    assign general_written = (REG_WDATA_IN & general_write_mask)
        | (state.general_mode_cfg & ~general_write_mask);
    assign transmit_written = REG_WDATA_IN & `RMT_TRANSMIT_WMASK;
    // only the receive crc enable is kept of the receive mode register
    assign receive_written = REG_WDATA_IN & `RMT_RECEIVE_WMASK;
    assign polarity_toggle = REG_WDATA_IN[`RMT_BIT_POLARITY] != envelope_in_polarity;

    // unmapped addresses read as zero; a read sees the value before a same-cycle write
    always_comb begin
        read_value = 8'h00;
        if (rd_general) begin
            read_value = state.general_mode_cfg;
        end else if (rd_transmit) begin
            read_value = state.transmit_mode_cfg;
        end else if (rd_receive) begin
            read_value = state.receive_mode_cfg;
        end else begin
            read_value = 8'h00;
        end
    end

    always_comb begin
        next_state = state;
        // two stages before any logic reads the pin
        next_state.env_meta = ENVELOPE_INPUT_PIN_IN;
        next_state.env_sync = state.env_meta;
        // one-cycle event whenever a write changes the polarity bit
        next_state.activity = wr_general & polarity_toggle;
        // read data stands for one cycle, then returns to zero
        next_state.rd_data = read_value;
        if (wr_general) begin
            next_state.general_mode_cfg = general_written;
        end
        if (wr_transmit) begin
            next_state.transmit_mode_cfg = transmit_written;
        end
        if (wr_receive) begin
            next_state.receive_mode_cfg = receive_written;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state.general_mode_cfg <= `RMT_GENERAL_RESET;
            state.transmit_mode_cfg <= `RMT_TRANSMIT_RESET;
            state.receive_mode_cfg <= `RMT_RECEIVE_RESET;
            state.rd_data <= 8'h00;
            state.env_meta <= 1'b0;
            state.env_sync <= 1'b0;
            state.activity <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // the protocol bit order (lsb first) overrides software during rf traffic
    assign high_order = crc_high_bit_order & ~RF_ACTIVE_IN;

    // each byte is mirrored on its own; the bytes keep their places
    for (genvar b = 0; b < BYTE_BITS; b++) begin : g_mirror
        assign crc_reversed[b] = CRC_RAW_IN[BYTE_BITS - 1 - b];
        assign crc_reversed[BYTE_BITS + b] = CRC_RAW_IN[2 * BYTE_BITS - 1 - b];
    end

    assign crc_shown = high_order ? crc_reversed : CRC_RAW_IN;

    // automatic seed: 6363h when either direction runs crc, else zero
    assign auto_crc_used = send_crc_append_on | receive_crc_check_on;
    assign auto_sel = auto_crc_used ? 2'h1 : 2'h0;
    assign seed_sel = RF_ACTIVE_IN ? auto_sel : crc_seed_select;

    always_comb begin
        case (seed_sel)
            2'h0: begin
                seed_value = `RMT_SEED_0;
            end
            2'h1: begin
                seed_value = `RMT_SEED_1;
            end
            2'h2: begin
                seed_value = `RMT_SEED_2;
            end
            default: begin
                seed_value = `RMT_SEED_3;
            end
        endcase
    end

    // a start request passes at once unless it must wait for the field
    assign field_ready = ~wait_for_field_before_send | FIELD_ON_IN;
    // pin read through the polarity, internal level always active low
    assign envelope_level_n = envelope_in_polarity ? ~state.env_sync : state.env_sync;
    // reserved codes are stored as written and only flagged
    assign rate_reserved = send_bit_rate > `RMT_RATE_MAX;

    assign REG_RDATA_OUT = state.rd_data;
    assign CRC_HIGH_BIT_ORDER_OUT = high_order;
    assign CRC_SEED_OUT = seed_value;
    assign CRC_RESULT_HIGH_BYTE_OUT = crc_shown[15:8];
    assign CRC_RESULT_LOW_BYTE_OUT = crc_shown[7:0];
    assign SEND_START_OUT = SEND_REQ_IN & field_ready;
    assign ENVELOPE_N_OUT = envelope_level_n;
    assign ENVELOPE_ACTIVITY_IRQ_OUT = state.activity;
    // software keeps crc on above 106 kBd; not enforced here
    assign SEND_CRC_APPEND_ON_OUT = send_crc_append_on;
    assign RECEIVE_CRC_CHECK_ON_OUT = receive_crc_check_on;
    assign SEND_BIT_RATE_OUT = send_bit_rate;
    assign SEND_RATE_RESERVED_OUT = rate_reserved;
    assign MODULATION_INVERT_OUT = modulation_invert;

endmodule
`default_nettype wire

// ---- sim/rmt_mode_regs_checker.sv ----
// concurrent checks on the ports of the mode configuration registers
`timescale 1ns/1ps
`default_nettype none
module rmt_mode_regs_checker (
    input wire logic CLK_IN, SYS_RST_IN, REG_WR_IN, REG_RD_IN, RF_ACTIVE_IN, FIELD_ON_IN,
    input wire logic SEND_REQ_IN, CRC_HIGH_BIT_ORDER_OUT, SEND_START_OUT,
    input wire logic ENVELOPE_ACTIVITY_IRQ_OUT, SEND_CRC_APPEND_ON_OUT,
    input wire logic RECEIVE_CRC_CHECK_ON_OUT, SEND_RATE_RESERVED_OUT,
    input wire logic [5:0] REG_ADDR_IN,
    input wire logic [7:0] REG_RDATA_OUT, CRC_RESULT_HIGH_BYTE_OUT, CRC_RESULT_LOW_BYTE_OUT,
    input wire logic [15:0] CRC_RAW_IN, CRC_SEED_OUT,
    input wire logic [2:0] SEND_BIT_RATE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // bit reversal inside each byte, never across the byte boundary
    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev[i] = v[(i & 8) + 7 - (i & 7)];
    endfunction
    wire [15:0] res = {CRC_RESULT_HIGH_BYTE_OUT, CRC_RESULT_LOW_BYTE_OUT};
    sequence s_irq_pulse;
        ENVELOPE_ACTIVITY_IRQ_OUT ##1 !ENVELOPE_ACTIVITY_IRQ_OUT;
    endsequence
    a_order_gate: assert property (RF_ACTIVE_IN |-> !CRC_HIGH_BIT_ORDER_OUT)
        else $error("bit order active during rf");
    a_byte_order: assert property (res == (CRC_HIGH_BIT_ORDER_OUT ? rev(CRC_RAW_IN) : CRC_RAW_IN))
        else $error("crc result bytes wrong");
    a_start_gate: assert property (SEND_START_OUT == (SEND_REQ_IN && FIELD_ON_IN) || !FIELD_ON_IN)
        else $error("start wrong with field on");
    a_seed_auto: assert property (RF_ACTIVE_IN |-> CRC_SEED_OUT == ((SEND_CRC_APPEND_ON_OUT ||
        RECEIVE_CRC_CHECK_ON_OUT) ? 16'h6363 : 16'h0000)) else $error("automatic seed wrong");
    a_seed_table: assert property (!RF_ACTIVE_IN |-> CRC_SEED_OUT inside {16'h0000, 16'h6363,
        16'ha671, 16'hffff}) else $error("seed outside table");
    a_rate_flag: assert property (SEND_RATE_RESERVED_OUT == SEND_BIT_RATE_OUT[2])
        else $error("reserved rate flag wrong");
    a_irq_cause: assert property (ENVELOPE_ACTIVITY_IRQ_OUT |-> $past(REG_WR_IN && REG_ADDR_IN == 6'h11))
        else $error("irq without general write");
    a_irq_pulse: assert property (ENVELOPE_ACTIVITY_IRQ_OUT && !REG_WR_IN |-> s_irq_pulse)
        else $error("irq longer than one cycle");
    a_seed_hold: assert property (!RF_ACTIVE_IN && !$past(RF_ACTIVE_IN) && $changed(CRC_SEED_OUT)
        |-> $past(REG_WR_IN && REG_ADDR_IN == 6'h11)) else $error("seed changed without general write");
    a_rdata_idle: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
        else $error("read data without read");
endmodule
bind rmt_mode_regs rmt_mode_regs_checker chk (.*);
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking testbench for the mode configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch %0t value differs", $time); end end
module tb;
    logic CLK_IN = 0, SYS_RST_IN = 1, REG_WR_IN = 0, REG_RD_IN = 0, RF_ACTIVE_IN = 0;
    logic FIELD_ON_IN = 0, SEND_REQ_IN = 0, ENVELOPE_INPUT_PIN_IN = 0;
    logic [5:0] REG_ADDR_IN = 0;
    logic [7:0] REG_WDATA_IN = 0, REG_RDATA_OUT, CRC_RESULT_HIGH_BYTE_OUT, CRC_RESULT_LOW_BYTE_OUT;
    logic [15:0] CRC_RAW_IN = 16'h0102, CRC_SEED_OUT;
    logic [2:0] SEND_BIT_RATE_OUT;
    logic CRC_HIGH_BIT_ORDER_OUT, SEND_START_OUT, ENVELOPE_N_OUT, ENVELOPE_ACTIVITY_IRQ_OUT;
    logic SEND_CRC_APPEND_ON_OUT, RECEIVE_CRC_CHECK_ON_OUT, SEND_RATE_RESERVED_OUT, MODULATION_INVERT_OUT;
    logic [15:0] seeds [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
    int error_cnt = 0, num_checks = 0;
    rmt_mode_regs uut (.*);
    always #20 CLK_IN = ~CLK_IN;
    task automatic results();
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic irq);
        @(negedge CLK_IN);
        {REG_ADDR_IN, REG_WDATA_IN, REG_WR_IN} = {a, d, 1'b1};
        @(negedge CLK_IN);
        REG_WR_IN = 0;
        `CHK(ENVELOPE_ACTIVITY_IRQ_OUT, irq)
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge CLK_IN);
        {REG_ADDR_IN, REG_RD_IN} = {a, 1'b1};
        @(negedge CLK_IN);
        REG_RD_IN = 0;
        `CHK(REG_RDATA_OUT, e)
    endtask
    task automatic t_general();
        wr(6'h11, 8'h00, 1);
        rd(6'h11, 8'h14);
        wr(6'h11, 8'hff, 1);
        rd(6'h11, 8'hbf);
        for (int i = 0; i < 4; i++) begin
            wr(6'h11, 8'(i), i == 0);
            `CHK(CRC_SEED_OUT, seeds[i])
        end
        wr(6'h11, 8'h80, 0);
        `CHK({CRC_HIGH_BIT_ORDER_OUT, CRC_RESULT_HIGH_BYTE_OUT, CRC_RESULT_LOW_BYTE_OUT}, 17'h18040)
        RF_ACTIVE_IN = 1;
        #1 `CHK({CRC_HIGH_BIT_ORDER_OUT, CRC_RESULT_HIGH_BYTE_OUT, CRC_RESULT_LOW_BYTE_OUT}, 17'h00102)
        `CHK(CRC_SEED_OUT, 16'h0000)
        @(negedge CLK_IN);
        RF_ACTIVE_IN = 0;
    endtask
    task automatic t_transmit();
        wr(6'h12, 8'hff, 0);
        rd(6'h12, 8'hf8);
        `CHK({SEND_CRC_APPEND_ON_OUT, SEND_BIT_RATE_OUT, SEND_RATE_RESERVED_OUT, MODULATION_INVERT_OUT}, 6'h3f)
        for (int i = 0; i < 4; i++) begin
            // crc generation is only dropped at the lowest rate
            wr(6'h12, {i != 0, 3'(i), 4'h0}, 0);
            `CHK({SEND_CRC_APPEND_ON_OUT, SEND_BIT_RATE_OUT, SEND_RATE_RESERVED_OUT}, {i != 0, 3'(i), 1'b0})
        end
        RF_ACTIVE_IN = 1;
        #1 `CHK(CRC_SEED_OUT, 16'h6363)
        wr(6'h12, 8'h00, 0);
        `CHK(CRC_SEED_OUT, 16'h0000)
        wr(6'h13, 8'h80, 0);
        `CHK(CRC_SEED_OUT, 16'h6363)
        `CHK(RECEIVE_CRC_CHECK_ON_OUT, 1'b1)
        rd(6'h13, 8'h80);
        RF_ACTIVE_IN = 0;
    endtask
    task automatic t_wait_env();
        wr(6'h11, 8'h20, 0);
        SEND_REQ_IN = 1;
        #1 `CHK(SEND_START_OUT, 1'b0)
        @(negedge CLK_IN);
        FIELD_ON_IN = 1;
        #1 `CHK(SEND_START_OUT, 1'b1)
        wr(6'h11, 8'h08, 1);
        ENVELOPE_INPUT_PIN_IN = 1;
        FIELD_ON_IN = 0;
        #1 `CHK(SEND_START_OUT, 1'b1)
        repeat (3) @(negedge CLK_IN);
        `CHK(ENVELOPE_N_OUT, 1'b0)
        wr(6'h11, 8'h00, 1);
        repeat (3) @(negedge CLK_IN);
        `CHK(ENVELOPE_N_OUT, 1'b1)
    endtask
    initial #200000 begin
        error_cnt++;
        results();
    end
    initial begin
        repeat (16) @(negedge CLK_IN);
        SYS_RST_IN = 0;
        rd(6'h11, 8'h3f);
        rd(6'h12, 8'h00);
        rd(6'h3f, 8'h00);
        `CHK(CRC_SEED_OUT, 16'hffff)
        t_general();
        t_transmit();
        t_wait_env();
        results();
    end
endmodule
`default_nettype wire
